// ---- design/rhc_params.svh ----
`ifndef RHC_PARAMS_SVH
`define RHC_PARAMS_SVH
// register byte offsets on the axi4-lite slave
`define RHC_OFF_OVERRIDE 12'h010
`define RHC_OFF_STATUS 12'h014
`define RHC_OFF_MASK 12'h024
`define RHC_OFF_OPTION 12'h028
`define RHC_OFF_EOL1 12'h030
`define RHC_OFF_EOL2 12'h034
`define RHC_OFF_CTRL 12'h040
// field positions
`define RHC_MSK_CTS 1
`define RHC_MSK_DSR 2
`define RHC_MSK_DCD 3
`define RHC_OPT_AUTO_RTS 0
`define RHC_OVR_RTS_VAL 0
`define RHC_OVR_DTR_VAL 1
`define RHC_OVR_RTS_EN 2
`define RHC_OVR_DTR_EN 3
`define RHC_CTL_DISC 0
`define RHC_CTL_RECOVER 1
// reset values
`define RHC_MASK_RST 8'h0e
`define RHC_EOL1_RST 8'h0d
`define RHC_EOL2_RST 8'h0a
`endif

// ---- design/rhc_pkg.sv ----
package rhc_pkg;
  // auto request-to-send sequencer states
  typedef enum logic [1:0] {
    RHC_IDLE,
    RHC_WAIT_CTS_LOW,
    RHC_RAISED,
    RHC_EOL_DROP
  } rhc_rts_state_t;
  typedef logic [1:0] rhc_resp_t;
  localparam rhc_resp_t RHC_OKAY = 2'b00;
  localparam rhc_resp_t RHC_SLVERR = 2'b10;
endpackage

// ---- design/rhc_handshake_ctrl.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - sample data set ready when observed
// - start characters only with observed cts
// - accept receive only with observed dcd
// - drive dtr and rts true when ready
// - autodisconnect forces dtr false
// - option bit zero enables auto rts
// - auto rts follows buffer, drops after eol
// - transmit only with rts and cts true
// - raise rts only after cts seen false
// - stop on empty, eol, or cts false
// - detect eol pair regardless of delete options
// - recovery command restores handshake sequencing
// - default ignores inputs, outputs held true
// - per-input observe mask, ignored reads true
// - mask 010 ignores only cts
// - rts true after reset unless auto
// - status bits 2..0 show live inputs
// - override bits force chosen outputs, except dtr while disconnect is held
`include "rhc_params.svh"
module rhc_handshake_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output rhc_pkg::rhc_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output rhc_pkg::rhc_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // rs-232 handshake pins (true = asserted)
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic dcd_pin,
  output logic rts_pin,
  output logic dtr_pin,
  // transmitter side
  input wire logic tx_buf_nonempty,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char,
  input wire logic tx_char_done,
  output logic tx_start_ok,
  // receiver side
  output logic rx_accept_ok,
  // device-level events
  input wire logic autodisc_req,
  input wire logic dev_clear
);
  import rhc_pkg::*;

  // two-flop synchronisers for the three pins
  // the pins are asynchronous levels; a single flop could hand logic a
  // metastable value, so only the second stage is ever read below.
  // both stages reset to zero: lines read false for two edges after release,
  // which the default mask hides.
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {dcd_pin, dsr_pin, cts_pin};
      sync2_ff <= sync1_ff;
    end
  end
  logic cts_s, dsr_s, dcd_s; // synchronised live levels
  assign cts_s = sync2_ff[0];
  assign dsr_s = sync2_ff[1];
  assign dcd_s = sync2_ff[2];

  // software registers
  logic [7:0] mask_ff; // one means ignore
  logic opt_auto_ff; // auto request-to-send option
  logic [3:0] ovr_ff; // output override
  logic [7:0] eol1_ff;
  logic [7:0] eol2_ff;
  logic disc_ff; // autodisconnect held
  logic recover_pulse; // one-cycle recovery strobe

  // effective inputs: ignored lines read as true
  logic cts_eff, dsr_eff, dcd_eff;
  assign cts_eff = cts_s | mask_ff[`RHC_MSK_CTS];
  assign dsr_eff = dsr_s | mask_ff[`RHC_MSK_DSR];
  assign dcd_eff = dcd_s | mask_ff[`RHC_MSK_DCD];

  // axi write channel: take address and data in either order
  logic aw_hold_ff, w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic bresp_err_ff;
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  logic wr_fire; // both halves present this cycle
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    case (a)
      `RHC_OFF_OVERRIDE, `RHC_OFF_STATUS, `RHC_OFF_MASK, `RHC_OFF_OPTION,
      `RHC_OFF_EOL1, `RHC_OFF_EOL2, `RHC_OFF_CTRL: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  // latch write halves and produce the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_err_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_err_ff <= !known_addr(awaddr_ff);
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_err_ff ? RHC_SLVERR : RHC_OKAY;

  // register updates; only byte lane 0 carries fields
  logic wr_lane0;
  assign wr_lane0 = wr_fire && wstrb_ff[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= `RHC_MASK_RST;
      opt_auto_ff <= 1'b0;
      ovr_ff <= 4'h0;
      eol1_ff <= `RHC_EOL1_RST;
      eol2_ff <= `RHC_EOL2_RST;
    end else if (wr_lane0) begin
      case (awaddr_ff)
        `RHC_OFF_MASK: mask_ff <= wdata_ff[7:0];
        `RHC_OFF_OPTION: opt_auto_ff <= wdata_ff[`RHC_OPT_AUTO_RTS];
        `RHC_OFF_OVERRIDE: ovr_ff <= wdata_ff[3:0];
        `RHC_OFF_EOL1: eol1_ff <= wdata_ff[7:0];
        `RHC_OFF_EOL2: eol2_ff <= wdata_ff[7:0];
        default: ;
      endcase
    end
  end

  // control register: disconnect level and recovery strobe
  logic ctrl_wr;
  assign ctrl_wr = wr_lane0 && (awaddr_ff == `RHC_OFF_CTRL);
  assign recover_pulse = (ctrl_wr && wdata_ff[`RHC_CTL_RECOVER]) || dev_clear;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disc_ff <= 1'b0;
    end else if (autodisc_req) begin
      disc_ff <= 1'b1; // set wins over a clear in the same cycle
    end else if (ctrl_wr) begin
      disc_ff <= wdata_ff[`RHC_CTL_DISC];
    end
  end

  // axi read channel: one-cycle answer
  // status reads the synchronised levels, not the masked ones, so software
  // sees the partner as it is even while a line is ignored.
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic rresp_err_ff;
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_err_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_err_ff <= !known_addr(s_axi_araddr);
      case (s_axi_araddr)
        `RHC_OFF_OVERRIDE: rdata_ff <= {28'h0, ovr_ff};
        `RHC_OFF_STATUS: rdata_ff <= {29'h0, dcd_s, dsr_s, cts_s};
        `RHC_OFF_MASK: rdata_ff <= {24'h0, mask_ff};
        `RHC_OFF_OPTION: rdata_ff <= {31'h0, opt_auto_ff};
        `RHC_OFF_EOL1: rdata_ff <= {24'h0, eol1_ff};
        `RHC_OFF_EOL2: rdata_ff <= {24'h0, eol2_ff};
        `RHC_OFF_CTRL: rdata_ff <= {31'h0, disc_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_err_ff ? RHC_SLVERR : RHC_OKAY;

  // end-of-line detector on sent characters, independent of delete/insert
  logic prev_eol1_ff; // last sent char matched the first eol char
  logic eol_sent; // pair completed on this character
  assign eol_sent = tx_char_done && tx_char_valid && prev_eol1_ff
                    && (tx_char == eol2_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn || recover_pulse) begin
      prev_eol1_ff <= 1'b0;
    end else if (tx_char_done && tx_char_valid) begin
      prev_eol1_ff <= (tx_char == eol1_ff);
    end
  end

  // auto request-to-send sequencer
  // held in idle while the option is off, so turning it on always starts
  // from a clean wait-for-cts-low handshake.
  // a partner that never drops cts parks the sequencer in the wait state;
  // only an empty buffer, clearing the option, a recovery strobe or device clear frees it.
  rhc_rts_state_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      RHC_IDLE: if (tx_buf_nonempty) nxt_st = RHC_WAIT_CTS_LOW;
      // wait for cts low before raising, so a stale cts cannot clock data
      RHC_WAIT_CTS_LOW: begin
        if (!tx_buf_nonempty) nxt_st = RHC_IDLE;
        else if (!cts_eff) nxt_st = RHC_RAISED;
      end
      RHC_RAISED: begin
        if (eol_sent) nxt_st = RHC_EOL_DROP;
        else if (!tx_buf_nonempty) nxt_st = RHC_IDLE;
      end
      RHC_EOL_DROP: nxt_st = RHC_IDLE; // one cycle here; rts stays low through idle and the wait state
      default: nxt_st = RHC_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !opt_auto_ff || recover_pulse) begin
      st_ff <= RHC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // automatic output levels, then override, then disconnect
  logic rts_auto, rts_q_ff, dtr_q_ff;
  assign rts_auto = opt_auto_ff ? (st_ff == RHC_RAISED) : 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_q_ff <= 1'b1;
      dtr_q_ff <= 1'b1;
    end else begin
      rts_q_ff <= ovr_ff[`RHC_OVR_RTS_EN] ? ovr_ff[`RHC_OVR_RTS_VAL] : rts_auto;
      dtr_q_ff <= disc_ff ? 1'b0
                : (ovr_ff[`RHC_OVR_DTR_EN] ? ovr_ff[`RHC_OVR_DTR_VAL] : 1'b1);
    end
  end
  assign rts_pin = rts_q_ff;
  assign dtr_pin = dtr_q_ff;

  // transfer gating
  assign tx_start_ok = rts_q_ff && cts_eff && dsr_eff && tx_buf_nonempty;
  assign rx_accept_ok = dcd_eff;

  // assertions
  AST_DTR_DISC: assert property (@(posedge aclk) disable iff (!aresetn)
    disc_ff |=> !dtr_pin) else $error("dtr not low during disconnect");
  AST_TX_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start_ok |-> (cts_s || mask_ff[`RHC_MSK_CTS])) else $error("start without cts");
  AST_RX_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!dcd_s && !mask_ff[`RHC_MSK_DCD]) |-> !rx_accept_ok) else $error("rx without dcd");
  AST_RTS_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start_ok |-> rts_pin) else $error("start without rts");
  AST_RTS_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    (!opt_auto_ff && !ovr_ff[`RHC_OVR_RTS_EN]) [*2] |-> rts_pin) else $error("rts dropped");
  AST_WAIT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == RHC_WAIT_CTS_LOW && cts_eff && opt_auto_ff && !recover_pulse)
    |=> st_ff != RHC_RAISED) else $error("rts raised while cts true");
  AST_EOL_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == RHC_RAISED && eol_sent && opt_auto_ff && !recover_pulse
     && !ovr_ff[`RHC_OVR_RTS_EN]) |=> ##1 !rts_pin) else $error("rts not dropped at eol");
  AST_EMPTY_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (opt_auto_ff && !tx_buf_nonempty && !ovr_ff[`RHC_OVR_RTS_EN]) [*3] |-> !rts_pin)
    else $error("rts high with empty buffer");
  AST_OVR_RTS: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr_ff[`RHC_OVR_RTS_EN] |=> rts_pin == $past(ovr_ff[`RHC_OVR_RTS_VAL]))
    else $error("rts override ignored");
  // an observed low dsr blocks any new character
  AST_DSR_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!dsr_s && !mask_ff[`RHC_MSK_DSR]) |-> !tx_start_ok)
    else $error("start without dsr");
  // an ignored or true dcd lets received characters in
  AST_RX_OPEN: assert property (@(posedge aclk) disable iff (!aresetn)
    dcd_eff |-> rx_accept_ok)
    else $error("rx refused with dcd open");
  // with cts ignored, dsr alone decides readiness
  AST_CTS_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
    (mask_ff[`RHC_MSK_CTS] && rts_pin && dsr_eff && tx_buf_nonempty) |-> tx_start_ok)
    else $error("start refused with cts ignored");
  // dtr stays true unless disconnected or forced
  AST_DTR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (!disc_ff && !ovr_ff[`RHC_OVR_DTR_EN]) |=> dtr_pin)
    else $error("dtr dropped without cause");
  // forced dtr follows its value bit when no disconnect is held
  AST_OVR_DTR: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovr_ff[`RHC_OVR_DTR_EN] && !disc_ff) |=> dtr_pin == $past(ovr_ff[`RHC_OVR_DTR_VAL]))
    else $error("dtr override ignored");
  // auto mode: rts is low outside the raised state
  AST_AUTO_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (opt_auto_ff && st_ff != RHC_RAISED && !ovr_ff[`RHC_OVR_RTS_EN]) |=> !rts_pin)
    else $error("auto rts high outside raised");
  // auto mode: rts is high in the raised state
  AST_AUTO_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    (opt_auto_ff && st_ff == RHC_RAISED && !ovr_ff[`RHC_OVR_RTS_EN]) |=> rts_pin)
    else $error("auto rts low while raised");
  // the raised state is only reached through the wait-for-low state
  AST_RAISE_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == RHC_RAISED)
    |-> ($past(st_ff) == RHC_WAIT_CTS_LOW || $past(st_ff) == RHC_RAISED))
    else $error("raised without waiting for cts low");
  // recovery always returns the sequencer to idle
  AST_RECOVER: assert property (@(posedge aclk) disable iff (!aresetn)
    recover_pulse |=> st_ff == RHC_IDLE)
    else $error("recovery did not reset sequencer");
  // a completed end-of-line pair moves to the drop state
  AST_EOL_STATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == RHC_RAISED && eol_sent && opt_auto_ff && !recover_pulse)
    |=> st_ff == RHC_EOL_DROP) else $error("eol pair not detected");
  // with the option clear the sequencer stays idle
  AST_OPT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !opt_auto_ff |=> st_ff == RHC_IDLE)
    else $error("sequencer ran with option off");
  // a disconnect request always latches
  AST_DISC_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    autodisc_req |=> disc_ff)
    else $error("disconnect request lost");
  // status read returns the synchronised levels of the accepting edge
  AST_STATUS_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `RHC_OFF_STATUS)
    |=> s_axi_rdata[2:0] == $past({dcd_s, dsr_s, cts_s})) else $error("status not live");
  // no character starts while rts is low
  AST_RTS_START: assert property (@(posedge aclk) disable iff (!aresetn)
    !rts_pin |-> !tx_start_ok)
    else $error("start with rts low");
  COV_AUTO_RAISE: cover property (@(posedge aclk) st_ff == RHC_WAIT_CTS_LOW ##1 st_ff == RHC_RAISED);
  // partner pauses a raised transfer by dropping cts
  COV_CTS_PAUSE: cover property (@(posedge aclk) st_ff == RHC_RAISED && !cts_eff);
  COV_EOL: cover property (@(posedge aclk) st_ff == RHC_EOL_DROP);
  COV_DISC: cover property (@(posedge aclk) disc_ff && !dtr_pin);
endmodule // rhc_handshake_ctrl

// ---- tb/rhc_modem_model.sv ----
`timescale 1ns/1ps
// behavioural half-duplex modem facing the handshake pins
module rhc_modem_model (
  // clock
  input wire logic aclk,
  // bench controls
  input wire logic follow,
  input wire logic stuck_cts,
  input wire logic [3:0] lag,
  input wire logic cts_lvl,
  input wire logic dsr_lvl,
  input wire logic dcd_lvl,
  // handshake pins
  input wire logic rts,
  output logic cts,
  output logic dsr,
  output logic dcd
);
  logic [3:0] cnt_ff; // cycles since rts rose, so the modem can answer slowly
  always_ff @(posedge aclk) begin
    if (!rts) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
  end
  // in follow mode cts falls with rts and never rises while rts is false; stuck is a fault on command
  assign cts = stuck_cts | (follow ? (rts && cnt_ff >= lag) : cts_lvl);
  assign dsr = dsr_lvl;
  assign dcd = dcd_lvl;
endmodule // rhc_modem_model

// ---- tb/rhc_handshake_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "rhc_params.svh"
module rhc_handshake_ctrl_tb;
  import rhc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  rhc_resp_t bresp, rresp;
  logic rts, dtr, cts, dsr, dcd, buf_ne, chr_v, start_ok, acc_ok, disc, clr, seen;
  logic follow, stuck, cts_l, dsr_l, dcd_l;
  logic [3:0] lag;
  logic [7:0] chr, e1, e2;
  logic [34:0] q[$]; // expected bus answers: write flag, resp, data
  int n_errors, cmp_count;
  rhc_handshake_ctrl u_rhc_handshake_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cts_pin(cts), .dsr_pin(dsr), .dcd_pin(dcd), .rts_pin(rts), .dtr_pin(dtr),
    .tx_buf_nonempty(buf_ne), .tx_char_valid(chr_v), .tx_char(chr), .tx_char_done(chr_v),
    .tx_start_ok(start_ok), .rx_accept_ok(acc_ok), .autodisc_req(disc), .dev_clear(clr));
  rhc_modem_model u_rhc_modem_model (.aclk(aclk), .follow(follow), .stuck_cts(stuck),
    .lag(lag), .cts_lvl(cts_l), .dsr_lvl(dsr_l), .dcd_lvl(dcd_l), .rts(rts), .cts(cts),
    .dsr(dsr), .dcd(dcd));
  task automatic cmp_bus(input logic [34:0] e, input logic [34:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_pin(input logic e, input logic g);
    cmp_bus({34'h0, e}, {34'h0, g});
  endtask
  task automatic end_sim;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // answers are judged at the falling edge, where the handshake is settled
  always @(negedge aclk) begin
    if (bvalid && bready) cmp_bus(q.pop_front(), {1'b1, bresp, 32'h0});
    if (rvalid && rready) cmp_bus(q.pop_front(), {1'b0, rresp, rdata});
  end
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ready is stable from the falling edge to the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input rhc_resp_t r);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    q.push_back({1'b1, r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input rhc_resp_t r);
    @(posedge aclk);
    q.push_back({1'b0, r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // one finished character, then watch rts for a dip
  task automatic txc(input logic [7:0] c);
    @(posedge aclk);
    chr <= c;
    chr_v <= 1'b1;
    @(posedge aclk);
    chr_v <= 1'b0;
    seen = 0;
    repeat (8) begin
      @(negedge aclk);
      seen |= !rts;
    end
  endtask
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, buf_ne, chr_v, disc, clr} = '0;
    {follow, stuck, cts_l, dsr_l, dcd_l, lag, chr, awaddr, araddr, wdata} = '0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(78));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    cmp_pin(1'b1, rts);
    cmp_pin(1'b1, dtr);
    rd(`RHC_OFF_MASK, 32'h0e, RHC_OKAY);
    wr(12'h0fc, 32'h1, RHC_SLVERR);
    rd(12'h0fc, 32'h0, RHC_SLVERR);
    buf_ne <= 1'b1;
    settle(2);
    cmp_pin(1'b1, start_ok);
    cmp_pin(1'b1, acc_ok);
    // every pin combination, observing all, then ignoring only cts
    for (int m = 0; m < 2; m++) begin
      wr(`RHC_OFF_MASK, m ? 32'h2 : 32'h0, RHC_OKAY);
      for (int i = 0; i < 8; i++) begin
        @(posedge aclk);
        {dcd_l, dsr_l, cts_l} <= i[2:0];
        settle(4);
        cmp_pin(i[1] & (i[0] | m[0]), start_ok);
        cmp_pin(i[2], acc_ok);
        rd(`RHC_OFF_STATUS, i, RHC_OKAY);
      end
    end
    wr(`RHC_OFF_OVERRIDE, 32'h6, RHC_OKAY);
    settle(2);
    cmp_pin(1'b0, rts);
    cmp_pin(1'b1, dtr);
    wr(`RHC_OFF_OVERRIDE, 32'ha, RHC_OKAY);
    @(posedge aclk);
    disc <= 1'b1;
    @(posedge aclk);
    disc <= 1'b0;
    settle(3);
    cmp_pin(1'b0, dtr);
    cmp_pin(1'b1, rts);
    wr(`RHC_OFF_CTRL, 32'h0, RHC_OKAY);
    wr(`RHC_OFF_OVERRIDE, 32'h0, RHC_OKAY);
    settle(2);
    cmp_pin(1'b1, dtr);
    // half-duplex partner with a slow answer and random line ends
    e1 = 8'h80 | 8'($urandom % 128);
    e2 = e1 ^ 8'h01;
    wr(`RHC_OFF_EOL1, {24'h0, e1}, RHC_OKAY);
    wr(`RHC_OFF_EOL2, {24'h0, e2}, RHC_OKAY);
    @(posedge aclk);
    {follow, dsr_l, dcd_l, stuck, lag, buf_ne} <= {4'hf, 4'h9, 1'b0};
    wr(`RHC_OFF_MASK, 32'h0, RHC_OKAY);
    wr(`RHC_OFF_OPTION, 32'h1, RHC_OKAY);
    settle(3);
    cmp_pin(1'b0, rts);
    @(posedge aclk);
    buf_ne <= 1'b1;
    settle(20);
    cmp_pin(1'b0, rts);
    @(posedge aclk);
    clr <= 1'b1;
    stuck <= 1'b0;
    @(posedge aclk);
    clr <= 1'b0;
    settle(4);
    cmp_pin(1'b1, rts);
    cmp_pin(1'b0, start_ok);
    settle(12);
    cmp_pin(1'b1, start_ok);
    txc(8'h20 + 8'($urandom % 95));
    txc(e2);
    cmp_pin(1'b0, seen);
    txc(e1);
    txc(e2);
    cmp_pin(1'b1, seen);
    settle(20);
    cmp_pin(1'b1, rts);
    @(posedge aclk);
    buf_ne <= 1'b0;
    settle(3);
    cmp_pin(1'b0, rts);
    cmp_pin(1'b0, start_ok);
    wr(`RHC_OFF_OPTION, 32'h0, RHC_OKAY);
    settle(3);
    cmp_pin(1'b1, rts);
    end_sim();
  end
endmodule // rhc_handshake_ctrl_tb
